//--- mut_defines.vh
// Constants for the muting sequence controller: offsets, fields, resets, times
// What this block does
// - Concurrent: both leading-pair sensors occupied, any order, within sensor time starts muting.
// - Four-sensor modes start a cycle only with all sensors clear and curtain free.
// - L mode starts a cycle only with sensor_a1, sensor_a2 clear and curtain free.
// - Cycle timeout, ten seconds to unlimited, ends muting at once when it expires.
// - Without the enable option muting is always enabled and enable is ignored.
// - Enable/disable mode arms a cycle only on an enable rising edge.
// - Enable/disable mode: enable falling edge ends muting at once; a running blind time is not cut short.
// - Enable-only mode never ends muting by enable; enable must fall before re-arming.
// - Concurrent direction: A then B, B then A, or either order.
// - Sequential direction: sensor_a1 to sensor_b4, reverse, or either.
// - Close on curtain rising, or on the third sensor in travel order clearing.
// - Blind time holds curtain seen free after close; four-sensor modes curtain close only.
// - Reject activation when the activating pair interval exceeds the sensor time.
// - With minimum sensor time, require at least 150 ms between pair occupations.
// - L mode ends muting when the curtain is free after the sensors cleared.
// - L mode end timer starts at first sensor release and ends muting on expiry.
// - Sequential: sensors occupied strictly one after another, no limit between pairs.
// - Muting is a temporary automatic bypass of the protective curtain.
`ifndef MUT_DEFINES_VH
`define MUT_DEFINES_VH

// Clock and tick
`define MUT_CLK_NS 50
`define MUT_TICK_NS 1000000
`define MUT_CLK_PER_MS (`MUT_TICK_NS / `MUT_CLK_NS)
`define MUT_MS_PER_S 32'h000003E8
`define MUT_MIN_SENS_MS 13'h0096
`define MUT_MIN_TIMEOUT_S 16'h000A

// Register byte addresses
`define MUT_ADR_CTRL 8'h00
`define MUT_ADR_TIME0 8'h04
`define MUT_ADR_TIME1 8'h08
`define MUT_ADR_STAT 8'h0C

// Control fields
`define MUT_CTRL_MASK 32'h000001FF
`define MUT_CTRL_RST 32'h00000000
`define MUT_MODE_CONC 2'h0
`define MUT_MODE_SEQ 2'h1
`define MUT_MODE_L 2'h2
`define MUT_DIR_FWD 2'h0
`define MUT_DIR_REV 2'h1
`define MUT_F_CLOSE_SENSOR 4
`define MUT_F_EN_OPT 5
`define MUT_F_EN_ONLY 6
`define MUT_F_BLIND 7
`define MUT_F_MIN_ST 8

// Timing fields, all in milliseconds except the timeout in seconds
`define MUT_TIME0_MASK 32'h1FFF1FFF
`define MUT_TIME0_RST 32'h09C407D0
`define MUT_TIME1_MASK 32'h03FFFFFF
`define MUT_TIME1_RST 32'h00FA000A

// Status fields
`define MUT_F_REJECT 14

`endif

//--- mut_ms_tick.v
// Millisecond enable divider for the muting controller
`timescale 1ns/10ps
`default_nettype none
module mut_ms_tick #(
  parameter DIV = 20000,
  parameter W = 15
) (
  input wire mclk,
  input wire sys_rst,
  output reg tick_q
);
  // End count is trimmed on purpose to the counter width
  localparam integer LAST_I = DIV - 1;
  localparam [W-1:0] LAST = LAST_I[W-1:0];
  reg [W-1:0] cnt_q;

  // One-cycle pulse every DIV clocks
  always @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q <= {W{1'b0}};
      tick_q <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q <= {W{1'b0}};
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end
endmodule // mut_ms_tick
`default_nettype wire

//--- mut_muting_ctrl.v
// Muting sequence controller with a classic Wishbone register slave
//
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "mut_defines.vh"
module mut_muting_ctrl #(
  parameter CLK_PER_MS = `MUT_CLK_PER_MS
) (
  input wire mclk,
  input wire sys_rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire sensor_a1,
  input wire sensor_a2,
  input wire sensor_b3,
  input wire sensor_b4,
  input wire curtain_in,
  input wire enable_in,
  output reg mute_out_q,
  output reg curtain_ok_q
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_FIRST = 4'h2;
  localparam [3:0] ST_MUTE = 4'h4;
  localparam [3:0] ST_BLIND = 4'h8;

  // Byte-lane merge for register writes
  function [31:0] wb_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer i;
    begin
      wb_merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          wb_merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  reg [5:0] sync1_q, sync2_q, prev_q;
  reg [2:0] settle_q;
  reg [3:0] st_q, st_d;
  reg [31:0] ctrl_q, time0_q, time1_q, rd_d;
  reg [12:0] pair_ms_q, aux_ms_q;
  reg [31:0] cyc_ms_q;
  reg armed_q, ready_q, dir_rev_q, seen3_q, end_run_q, reject_q;
  reg abort_c;
  wire tick;
  wire [5:0] pin_raw;

  mut_ms_tick #(
    .DIV(CLK_PER_MS),
    .W(32)
  ) u_tick (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .tick_q(tick)
  );

  // Pins are asynchronous to mclk, so every one passes two flops
  assign pin_raw = {enable_in, curtain_in, sensor_b4, sensor_b3, sensor_a2, sensor_a1};
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_sync
      always @(posedge mclk) begin
        if (sys_rst) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          prev_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= pin_raw[g];
          sync2_q[g] <= sync1_q[g];
          prev_q[g] <= sync2_q[g];
        end
      end
    end
  endgenerate

  // Edges are trusted only once the sync chain holds real pin values;
  // otherwise an enable held high through reset would look like a rise
  always @(posedge mclk) begin
    if (sys_rst) begin
      settle_q <= 3'h0;
    end else begin
      settle_q <= {settle_q[1:0], 1'b1};
    end
  end

  wire live = settle_q[2];
  wire cur = sync2_q[4];
  wire en = sync2_q[5];
  wire en_rise = live & en & ~prev_q[5];
  wire en_fall = live & ~en & prev_q[5];
  wire cur_rise = live & cur & ~prev_q[4];

  // Configuration decode
  wire [1:0] mode = ctrl_q[1:0];
  wire [1:0] dir = ctrl_q[3:2];
  wire mode_l = (mode == `MUT_MODE_L);
  wire mode_seq = (mode == `MUT_MODE_SEQ);
  wire close_sensor = ctrl_q[`MUT_F_CLOSE_SENSOR];
  wire en_opt = ctrl_q[`MUT_F_EN_OPT];
  wire en_only = ctrl_q[`MUT_F_EN_ONLY];
  wire [12:0] sens_ms = time0_q[12:0];
  wire [12:0] end_ms = time0_q[28:16];
  wire [15:0] to_s = time1_q[15:0];
  wire [12:0] blind_ms = {3'h0, time1_q[25:16]};
  wire [15:0] to_eff = (to_s < `MUT_MIN_TIMEOUT_S) ? `MUT_MIN_TIMEOUT_S : to_s;
  wire [31:0] to_ms = {16'h0000, to_eff} * `MUT_MS_PER_S;

  // L mode only looks at the first pair
  wire [3:0] sm = mode_l ? {2'h0, sync2_q[1:0]} : sync2_q[3:0];
  wire prelim = (sm == 4'h0) & cur;
  wire arm_ok = ~en_opt | armed_q;
  wire fwd_ok = (dir != `MUT_DIR_REV);
  wire rev_ok = (dir != `MUT_DIR_FWD) & ~mode_l;

  // Sequential start needs the outermost sensor alone; concurrent either of the pair
  wire start_fwd = fwd_ok & (mode_seq ? (sm == 4'h1) :
                   (sm[1:0] != 2'h0) & (sm[3:2] == 2'h0));
  wire start_rev = rev_ok & (mode_seq ? (sm == 4'h8) :
                   (sm[3:2] != 2'h0) & (sm[1:0] == 2'h0));

  // Leading and trailing pair as seen in the latched travel direction
  wire [1:0] lead = dir_rev_q ? sm[3:2] : sm[1:0];
  wire [1:0] other = dir_rev_q ? sm[1:0] : sm[3:2];
  wire first_bit = dir_rev_q ? sm[3] : sm[0];
  wire pair_done = (lead == 2'h3) & (other == 2'h0);
  wire too_late = (pair_ms_q > sens_ms);
  wire too_soon = ctrl_q[`MUT_F_MIN_ST] & (pair_ms_q < `MUT_MIN_SENS_MS);
  wire abort_first = (lead == 2'h0) | (other != 2'h0) | (mode_seq & ~first_bit) |
                     too_late | (pair_done & too_soon);

  // Third sensor in travel order and trailing-pair order check
  wire third = dir_rev_q ? sm[1] : sm[2];
  wire seq_bad = mode_seq & ~seen3_q &
                 (dir_rev_q ? (sm[0] & ~sm[1]) : (sm[3] & ~sm[2]));

  // Close conditions per mode
  wire close_4 = close_sensor ? (seen3_q & ~third) : cur_rise;
  wire close_l = (sm[1:0] == 2'h0) & cur;
  wire end_exp = end_run_q & (aux_ms_q >= end_ms);
  wire close_any = mode_l ? (close_l | end_exp) : close_4;
  wire blind_ok = ctrl_q[`MUT_F_BLIND] & (mode_l | ~close_sensor);
  wire blind_done = (aux_ms_q >= blind_ms);

  // Abnormal ends: timeout, or enable falling in enable/disable mode only
  wire to_hit = (to_s != 16'h0000) & (cyc_ms_q >= to_ms);
  wire dis_hit = en_opt & ~en_only & en_fall;
  wire kill = to_hit | dis_hit;

  // Next state
  always @* begin
    st_d = st_q;
    abort_c = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (ready_q && (start_fwd || start_rev)) begin
          st_d = ST_FIRST;
        end
      end
      ST_FIRST: begin
        if (kill || abort_first) begin
          st_d = ST_IDLE;
          abort_c = 1'b1;
        end else if (pair_done) begin
          st_d = ST_MUTE;
        end
      end
      ST_MUTE: begin
        if (kill || seq_bad) begin
          st_d = ST_IDLE;
          abort_c = 1'b1;
        end else if (close_any) begin
          st_d = blind_ok ? ST_BLIND : ST_IDLE;
        end
      end
      ST_BLIND: begin
        if (blind_done) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  wire go_first = (st_q == ST_IDLE) & (st_d == ST_FIRST);
  wire go_mute = (st_q == ST_FIRST) & (st_d == ST_MUTE);

  // Sequencer registers and millisecond counters
  always @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      armed_q <= 1'b0;
      ready_q <= 1'b0;
      dir_rev_q <= 1'b0;
      seen3_q <= 1'b0;
      end_run_q <= 1'b0;
      pair_ms_q <= 13'h0000;
      aux_ms_q <= 13'h0000;
      cyc_ms_q <= 32'h00000000;
      mute_out_q <= 1'b0;
      curtain_ok_q <= 1'b0;
    end else begin
      st_q <= st_d;
      // Only an edge arms; the set wins over a same-cycle consume
      if (en_opt && en_rise) begin
        armed_q <= 1'b1;
      end else if (go_mute || (dis_hit && !en_only) || !en_opt) begin
        armed_q <= 1'b0;
      end
      ready_q <= (st_q == ST_IDLE) & (st_d == ST_IDLE) & prelim & arm_ok;
      if (go_first) begin
        dir_rev_q <= start_rev;
      end
      if (go_first || st_q != ST_MUTE) begin
        seen3_q <= 1'b0;
      end else if (third) begin
        seen3_q <= 1'b1;
      end
      // End timer runs from the first release of a leading sensor
      if (st_q != ST_MUTE || st_d != ST_MUTE) begin
        end_run_q <= 1'b0;
      end else if (mode_l && lead != 2'h3) begin
        end_run_q <= 1'b1;
      end
      if (go_first) begin
        pair_ms_q <= 13'h0000;
      end else if (tick && st_q == ST_FIRST && pair_ms_q != 13'h1FFF) begin
        pair_ms_q <= pair_ms_q + 13'h0001;
      end
      // Aux counter serves the end timer and blind time, saturating
      if (st_d != st_q || (st_q == ST_MUTE && !end_run_q)) begin
        aux_ms_q <= 13'h0000;
      end else if (tick && aux_ms_q != 13'h1FFF) begin
        aux_ms_q <= aux_ms_q + 13'h0001;
      end
      if (go_first) begin
        cyc_ms_q <= 32'h00000000;
      end else if (tick && (st_q == ST_FIRST || st_q == ST_MUTE)) begin
        cyc_ms_q <= cyc_ms_q + 32'h00000001;
      end
      mute_out_q <= (st_d == ST_MUTE);
      // Curtain seen free while muting or blind, whatever its level
      curtain_ok_q <= cur | (st_d == ST_MUTE) | (st_d == ST_BLIND);
    end
  end

  // Wishbone classic slave: ack one cycle after the request, dropped next cycle
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i;
  wire [31:0] ctrl_new = wb_merge(ctrl_q, wb_dat_i, wb_sel_i);
  wire [31:0] time0_new = wb_merge(time0_q, wb_dat_i, wb_sel_i);
  wire [31:0] time1_new = wb_merge(time1_q, wb_dat_i, wb_sel_i);
  wire rej_clr = wb_wr & (wb_adr_i == `MUT_ADR_STAT) & wb_sel_i[1] & wb_dat_i[`MUT_F_REJECT];

  // Read mux; unmapped addresses read zero
  always @* begin
    case (wb_adr_i)
      `MUT_ADR_CTRL: rd_d = ctrl_q;
      `MUT_ADR_TIME0: rd_d = time0_q;
      `MUT_ADR_TIME1: rd_d = time1_q;
      `MUT_ADR_STAT: rd_d = {17'h00000, reject_q, en, cur, sync2_q[3:0],
                             dir_rev_q, armed_q, ready_q, mute_out_q, st_q};
      default: rd_d = 32'h00000000;
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      ctrl_q <= `MUT_CTRL_RST;
      time0_q <= `MUT_TIME0_RST;
      time1_q <= `MUT_TIME1_RST;
      reject_q <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= rd_d;
      end
      if (wb_wr && wb_adr_i == `MUT_ADR_CTRL) begin
        ctrl_q <= ctrl_new & `MUT_CTRL_MASK;
      end
      if (wb_wr && wb_adr_i == `MUT_ADR_TIME0) begin
        time0_q <= time0_new & `MUT_TIME0_MASK;
      end
      if (wb_wr && wb_adr_i == `MUT_ADR_TIME1) begin
        time1_q <= time1_new & `MUT_TIME1_MASK;
      end
      // Reject flag: a new reject wins over a same-cycle clear
      if (abort_c) begin
        reject_q <= 1'b1;
      end else if (rej_clr) begin
        reject_q <= 1'b0;
      end
    end
  end
endmodule // mut_muting_ctrl
`default_nettype wire

//--- mut_sensor_model.sv
// Behavioural muting sensors and light curtain facing the controller
`timescale 1ns/10ps
`default_nettype none
module mut_sensor_model (
  input wire logic mclk,
  output var logic sensor_a1,
  output var logic sensor_a2,
  output var logic sensor_b3,
  output var logic sensor_b4,
  output var logic curtain_in
);
  // Pallet starts outside the opening: beams clear, curtain free
  initial {sensor_a1, sensor_a2, sensor_b3, sensor_b4, curtain_in} = 5'h01;

  // Beams move only just after an edge; order is {a1, a2, b3, b4, curtain}
  task automatic put(input logic [4:0] v);
    @(posedge mclk);
    {sensor_a1, sensor_a2, sensor_b3, sensor_b4, curtain_in} <= v;
  endtask
endmodule // mut_sensor_model
`default_nettype wire

//--- mut_properties.sv
// Port-level checks for the muting sequence controller
`timescale 1ns/10ps
`default_nettype none
module mut_properties (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sensor_a1,
  input wire logic sensor_a2,
  input wire logic sensor_b3,
  input wire logic sensor_b4,
  input wire logic curtain_in,
  input wire logic enable_in,
  input wire logic mute_out_q,
  input wire logic curtain_ok_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire [3:0] occ = {sensor_a1, sensor_a2, sensor_b3, sensor_b4};

  // Bus answers each fresh request next cycle, as a single pulse
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  hole_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h0C |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  // Sync lag is at least two edges, so the pins two edges back must show a pair
  pair_needed_a: assert property ($rose(mute_out_q) |-> $countones($past(occ, 2)) >= 2)
    else $error("muting started without a sensor pair");
  clear_idle_a: assert property ((occ == 4'h0) [*5] |=> !$rose(mute_out_q))
    else $error("muting started with all sensors clear");
  bypass_a: assert property (mute_out_q && $past(mute_out_q) |-> curtain_ok_q)
    else $error("curtain not bypassed while muting");
  curtain_hold_a: assert property (
    mute_out_q && $fell(curtain_in) && $stable(enable_in) |=> mute_out_q)
    else $error("curtain interruption ended muting");
  curtain_pass_a: assert property (curtain_in [*5] |-> curtain_ok_q)
    else $error("free curtain not passed on");

  cover property ($rose(mute_out_q));
  cover property ($fell(mute_out_q) && curtain_in);
  cover property (curtain_ok_q && !curtain_in && !mute_out_q);
endmodule // mut_properties

bind mut_muting_ctrl mut_properties chk_u (.mclk(mclk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sensor_a1(sensor_a1), .sensor_a2(sensor_a2),
  .sensor_b3(sensor_b3), .sensor_b4(sensor_b4), .curtain_in(curtain_in),
  .enable_in(enable_in), .mute_out_q(mute_out_q), .curtain_ok_q(curtain_ok_q));
`default_nettype wire

//--- muting_sequence_controller_tb.sv
// Self-checking bench for the muting sequence controller
`timescale 1ns/10ps
`default_nettype none
`include "mut_defines.vh"
module muting_sequence_controller_tb;
  // Short millisecond keeps the ten-second timeout inside the run budget
  localparam int MS = 4;
  logic mclk, sys_rst, cyc, stb, we, en, ack, mute, cok, a1, a2, b3, b4, cur;
  logic [7:0] adr;
  logic [31:0] dat, rdat, q;
  logic [3:0] sel;
  int failures, cmp_count, cycles;

  mut_muting_ctrl #(.CLK_PER_MS(MS)) dut_u (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .sensor_a1(a1), .sensor_a2(a2), .sensor_b3(b3),
    .sensor_b4(b4), .curtain_in(cur), .enable_in(en), .mute_out_q(mute), .curtain_ok_q(cok));
  mut_sensor_model pm_u (.mclk(mclk), .sensor_a1(a1), .sensor_a2(a2), .sensor_b3(b3),
    .sensor_b4(b4), .curtain_in(cur));

  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Classic cycle: hold until ack is sampled, take data at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge mclk);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
    do @(posedge mclk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0, 4'hF);
    chk($sformatf("reg %h", a), q, x);
  endtask
  task automatic cfg(input logic [31:0] c);
    wb(1'b1, `MUT_ADR_CTRL, c, 4'hF);
  endtask
  // Set beams {a1, a2, b3, b4, curtain}, then let ms milliseconds pass
  task automatic s(input logic [4:0] v, input int ms);
    pm_u.put(v);
    repeat (ms * MS + 4) @(posedge mclk);
  endtask
  task automatic e(input logic v);
    @(posedge mclk);
    en <= v;
    repeat (2 * MS) @(posedge mclk);
  endtask
  // Clear the opening and free the curtain; a rising curtain closes the cycle
  task automatic done();
    s(5'h00, 2);
    s(5'h01, 2);
    chk("mute_end", mute, 0);
  endtask
  task automatic pair(input logic [31:0] x);
    s(5'h11, 2);
    s(5'h19, 2);
    chk("mute_pair", mute, x);
  endtask

  task automatic t_regs();
    rd(`MUT_ADR_CTRL, 32'h0);
    rd(`MUT_ADR_TIME0, 32'h09C407D0);
    rd(`MUT_ADR_TIME1, 32'h00FA000A);
    rd(8'h40, 32'h0);
    wb(1'b1, `MUT_ADR_CTRL, 32'hFFFFFFFF, 4'h3);
    rd(`MUT_ADR_CTRL, 32'h000001FF);
    wb(1'b1, `MUT_ADR_TIME0, 32'h09C400C8, 4'hF);
    wb(1'b1, `MUT_ADR_TIME1, 32'h0, 4'h3);
    rd(`MUT_ADR_TIME1, 32'h00FA0000);
  endtask
  // Enable pin stays low here, so the option being off must not block muting
  task automatic t_conc();
    cfg(32'h80);
    s(5'h11, 2);
    chk("mute_one", mute, 0);
    s(5'h19, 2);
    chk("mute_start", mute, 1);
    s(5'h18, 2);
    chk("mute_hold", mute, 1);
    s(5'h06, 2);
    s(5'h07, 2);
    chk("curtain_close", mute, 0);
    s(5'h00, 2);
    chk("blind_on", cok, 1);
    s(5'h00, 260);
    chk("blind_off", cok, 0);
    s(5'h01, 2);
  endtask
  task automatic t_rej();
    cfg(32'h0);
    s(5'h11, 210);
    s(5'h19, 2);
    chk("slow_pair", mute, 0);
    s(5'h00, 2);
    s(5'h10, 2);
    s(5'h18, 2);
    chk("curtain_busy", mute, 0);
    s(5'h01, 2);
    cfg(32'h100);
    pair(0);
    s(5'h01, 2);
    s(5'h11, 160);
    s(5'h19, 2);
    chk("min_time_ok", mute, 1);
    done();
  endtask
  // Entering from the far end is refused forward and accepted in reverse
  task automatic t_dir();
    for (int d = 0; d < 3; d++) begin
      cfg(32'(d << 2));
      s(5'h03, 2);
      s(5'h07, 2);
      chk("far_entry", mute, (d == 0) ? 0 : 1);
      done();
    end
  endtask
  task automatic t_seq();
    cfg(32'h11);
    pair(1);
    s(5'h1D, 2);
    s(5'h1F, 2);
    s(5'h0F, 2);
    s(5'h07, 2);
    chk("seq_hold", mute, 1);
    s(5'h03, 2);
    chk("third_clear", mute, 0);
    s(5'h01, 2);
    pair(1);
    s(5'h1B, 2);
    chk("order_fault", mute, 0);
    s(5'h01, 2);
  endtask
  task automatic t_en();
    cfg(32'h20);
    e(1);
    pair(1);
    done();
    pair(0);
    s(5'h01, 2);
    e(0);
    e(1);
    pair(1);
    e(0);
    chk("disable", mute, 0);
    s(5'h01, 2);
    cfg(32'h60);
    e(1);
    pair(1);
    e(0);
    chk("enable_only", mute, 1);
    done();
  endtask
  // L mode ignores the far pair; it closes on a freed opening or on its end timer
  task automatic t_l();
    cfg(32'h2);
    s(5'h03, 2);
    s(5'h13, 2);
    s(5'h1B, 2);
    chk("l_start", mute, 1);
    s(5'h0B, 2);
    s(5'h02, 2);
    chk("l_wait_free", mute, 1);
    s(5'h03, 2);
    chk("l_close", mute, 0);
    pair(1);
    s(5'h08, 2490);
    chk("l_timer_run", mute, 1);
    s(5'h08, 20);
    chk("l_timer_end", mute, 0);
    s(5'h01, 2);
  endtask
  // A cycle that never closes is cut at ten seconds and leaves the reject flag set
  task automatic t_to();
    cfg(32'h0);
    wb(1'b1, `MUT_ADR_STAT, 32'h00004000, 4'h2);
    wb(1'b1, `MUT_ADR_TIME1, 32'h0000000A, 4'h3);
    pair(1);
    s(5'h19, 9980);
    chk("to_running", mute, 1);
    s(5'h19, 30);
    chk("to_expired", mute, 0);
    rd(`MUT_ADR_STAT, 32'h00005301);
    s(5'h01, 2);
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Free-running 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 70000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    {sys_rst, cyc, stb, we, en, adr, dat, sel} = {5'h10, 44'h0};
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    t_regs();
    t_conc();
    t_rej();
    t_dir();
    t_seq();
    t_en();
    t_l();
    t_to();
    end_of_test();
  end
endmodule // muting_sequence_controller_tb
`default_nettype wire
